// ===== hw/spisc_pkg.sv
package spisc_pkg;

   // register indices; the byte address is four times the index
   localparam logic [2:0] IDX_CTRL1  = 3'h0;
   localparam logic [2:0] IDX_CTRL2  = 3'h1;
   localparam logic [2:0] IDX_BAUD   = 3'h2;
   localparam logic [2:0] IDX_STATUS = 3'h3;
   localparam logic [2:0] IDX_DATA   = 3'h5;

   // first_control_register fields
   localparam int CTRL1_ENABLE_BIT = 6;
   localparam int CTRL1_CSEL_BIT   = 4;
   localparam int CTRL1_CLOCK_POLARITY_BIT   = 3;
   localparam int CTRL1_CLOCK_PHASE_BIT   = 2;
   // second_control_register fields
   localparam int CTRL2_MFDE_BIT   = 4;
   // rate register fields
   localparam int BAUD_PRE_LSB     = 4;
   localparam int BAUD_SEL_LSB     = 0;
   // transfer_status fields
   localparam int STAT_TC_BIT      = 7;
   localparam int STAT_TE_BIT      = 5;
   localparam int STAT_MF_BIT      = 4;

   localparam logic [7:0] CTRL1_RESET = 8'h04;
   localparam logic [7:0] CTRL2_RESET = 8'h00;
   localparam logic [7:0] BAUD_RESET  = 8'h00;

   // eight bits per byte, sixteen clock edges per byte
   localparam logic [2:0] LAST_BIT  = 3'h7;
   localparam logic [3:0] LAST_EDGE = 4'hF;

   typedef enum logic [1:0] {
      SPISC_IDLE = 2'b00,
      SPISC_LEAD = 2'b01,
      SPISC_RUN  = 2'b10
   } spisc_state_t;

endpackage

// ===== hw/spisc_rate_div.sv
`timescale 1ns/1ns
module spisc_rate_div (
   input  wire logic       sys_clk_in,
   input  wire logic       rst_b_in,
   input  wire logic       clear_in,
   input  wire logic [2:0] preselect_in,
   input  wire logic [2:0] select_in,
   output logic            tick_out
);
   // one tick per half serial clock: (pre + 1) * 2^sel bus cycles
   logic [10:0] half_m1;
   logic [10:0] cnt_reg;

   assign half_m1 = 11'(({8'h00, preselect_in} + 11'h001) << select_in)
                    - 11'h001;

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_reg  <= 11'h000;
         tick_out <= 1'b0;
      end else if (clear_in) begin
         cnt_reg  <= 11'h000;
         tick_out <= 1'b0;
      end else if (cnt_reg == half_m1) begin
         cnt_reg  <= 11'h000;
         tick_out <= 1'b1;
      end else begin
         cnt_reg  <= cnt_reg + 11'h001;
         tick_out <= 1'b0;
      end
   end
endmodule

// ===== hw/spisc_core.sv
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ns
module spisc_core (
   input  wire logic        sys_clk_in,
   input  wire logic        rst_b_in,
   input  wire logic [2:0]  address_in,
   input  wire logic        read_in,
   input  wire logic        write_in,
   input  wire logic [3:0]  byteenable_in,
   input  wire logic [31:0] writedata_in,
   output logic [31:0]      readdata_out,
   output logic             waitrequest_out,
   input  wire logic        sck_in,
   output logic             sck_out,
   output logic             sck_oe_out,
   input  wire logic        mosi_in,
   output logic             mosi_out,
   output logic             mosi_oe_out,
   input  wire logic        miso_in,
   output logic             miso_out,
   output logic             miso_oe_out,
   input  wire logic        ss_b_in
);
   logic [7:0]   ctrl1_reg;
   logic [7:0]   ctrl2_reg;
   logic [7:0]   baud_reg;
   logic [7:0]   tx_buf_reg;
   logic [7:0]   rx_buf_reg;
   logic [7:0]   shift_reg;
   logic [7:0]   rx_byte;
   logic [7:0]   rd_mux;
   logic         tc_flag_reg;
   logic         te_flag_reg;
   logic         mf_flag_reg;
   logic         tc_armed_reg;
   logic         te_armed_reg;
   logic         mf_armed_reg;
   logic         latch_reg;
   logic         sck_prev_reg;
   logic [2:0]   bit_cnt_reg;
   logic [3:0]   edge_cnt_reg;
   spisc_pkg::spisc_state_t state_reg;

   logic rd_acc, wr_acc;
   logic stat_rd, data_rd, data_wr, ctrl1_wr;
   logic enable, master, clock_polarity, clock_phase, mfde;
   logic tick, mf_evt, cfg_chg, abort;
   logic tc_clear, tx_load, tx_take;
   logic edge_evt, odd_edge, sample_edge, shift_edge, done, din, busy;

   assign enable = ctrl1_reg[spisc_pkg::CTRL1_ENABLE_BIT];
   assign master = ctrl1_reg[spisc_pkg::CTRL1_CSEL_BIT];
   assign clock_polarity   = ctrl1_reg[spisc_pkg::CTRL1_CLOCK_POLARITY_BIT];
   assign clock_phase   = ctrl1_reg[spisc_pkg::CTRL1_CLOCK_PHASE_BIT];
   assign mfde   = ctrl2_reg[spisc_pkg::CTRL2_MFDE_BIT];

   // bus: every access answers on the cycle after it is first seen
   assign rd_acc   = read_in & ~waitrequest_out;
   assign wr_acc   = write_in & ~waitrequest_out & byteenable_in[0];
   assign stat_rd  = rd_acc && address_in == spisc_pkg::IDX_STATUS;
   assign data_rd  = rd_acc && address_in == spisc_pkg::IDX_DATA;
   assign data_wr  = wr_acc && address_in == spisc_pkg::IDX_DATA;
   assign ctrl1_wr = wr_acc && address_in == spisc_pkg::IDX_CTRL1;

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         waitrequest_out <= 1'b1;
      end else begin
         waitrequest_out <= ~((read_in | write_in) & waitrequest_out);
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      unique case (address_in)
         spisc_pkg::IDX_CTRL1:  rd_mux = ctrl1_reg;
         spisc_pkg::IDX_CTRL2:  rd_mux = ctrl2_reg;
         spisc_pkg::IDX_BAUD:   rd_mux = baud_reg;
         spisc_pkg::IDX_STATUS: begin
            rd_mux[spisc_pkg::STAT_TC_BIT] = tc_flag_reg;
            rd_mux[spisc_pkg::STAT_TE_BIT] = te_flag_reg;
            rd_mux[spisc_pkg::STAT_MF_BIT] = mf_flag_reg;
         end
         spisc_pkg::IDX_DATA:   rd_mux = rx_buf_reg;
         default:               rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         readdata_out <= 32'h0000_0000;
      end else if (read_in && waitrequest_out) begin
         readdata_out <= {24'h00_0000, rd_mux};
      end
   end

   // a fault drops master mode at once, even against a same-cycle write
   assign mf_evt = enable & master & mfde & ~ss_b_in;
   // master config edits kill the byte in flight
   assign cfg_chg = master &
                    ((ctrl1_wr && writedata_in[3:2] != ctrl1_reg[3:2]) ||
                     (wr_acc && address_in == spisc_pkg::IDX_BAUD));

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl1_reg <= spisc_pkg::CTRL1_RESET;
      end else begin
         if (ctrl1_wr) begin
            ctrl1_reg <= writedata_in[7:0];
         end
         if (mf_evt) begin
            ctrl1_reg[spisc_pkg::CTRL1_CSEL_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl2_reg <= spisc_pkg::CTRL2_RESET;
         baud_reg  <= spisc_pkg::BAUD_RESET;
      end else if (wr_acc) begin
         if (address_in == spisc_pkg::IDX_CTRL2) begin
            ctrl2_reg <= writedata_in[7:0];
         end
         if (address_in == spisc_pkg::IDX_BAUD) begin
            baud_reg <= writedata_in[7:0] & 8'h77;
         end
      end
   end

   // a status read arms each clear sequence with the flag value it saw
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tc_armed_reg <= 1'b0;
         te_armed_reg <= 1'b0;
         mf_armed_reg <= 1'b0;
      end else begin
         if (stat_rd) begin
            tc_armed_reg <= tc_flag_reg;
            te_armed_reg <= te_flag_reg;
            mf_armed_reg <= mf_flag_reg;
         end else begin
            if (data_rd) tc_armed_reg <= 1'b0;
            if (data_wr) te_armed_reg <= 1'b0;
            if (ctrl1_wr) mf_armed_reg <= 1'b0;
         end
      end
   end

   assign tc_clear = data_rd & tc_armed_reg;
   assign tx_load  = data_wr & te_armed_reg & te_flag_reg;

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tc_flag_reg <= 1'b0;
      end else if (done) begin
         tc_flag_reg <= 1'b1;
      end else if (tc_clear) begin
         tc_flag_reg <= 1'b0;
      end
   end

   // a byte landing on an unserviced flag is thrown away
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_buf_reg <= 8'h00;
      end else if (done && !(tc_flag_reg && !tc_clear)) begin
         rx_buf_reg <= rx_byte;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         te_flag_reg <= 1'b1;
         tx_buf_reg  <= 8'h00;
      end else if (tx_load) begin
         te_flag_reg <= 1'b0;
         tx_buf_reg  <= writedata_in[7:0];
      end else if (tx_take) begin
         te_flag_reg <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mf_flag_reg <= 1'b0;
      end else if (mf_evt) begin
         mf_flag_reg <= 1'b1;
      end else if (ctrl1_wr && mf_armed_reg) begin
         mf_flag_reg <= 1'b0;
      end
   end

   spisc_rate_div u_rate_div (
      .sys_clk_in   (sys_clk_in),
      .rst_b_in     (rst_b_in),
      .clear_in     (state_reg == spisc_pkg::SPISC_IDLE),
      .preselect_in (baud_reg[spisc_pkg::BAUD_PRE_LSB +: 3]),
      .select_in    (baud_reg[spisc_pkg::BAUD_SEL_LSB +: 3]),
      .tick_out     (tick)
   );

   // slave edges come from sampling sck, so it must be slower than
   // half the bus clock; the fastest divisor works only as master
   assign abort = mf_evt | cfg_chg | ~enable |
                  (~master & ss_b_in);
   assign busy  = master ? (state_reg != spisc_pkg::SPISC_IDLE)
                         : (edge_cnt_reg != 4'h0);
   assign tx_take = enable & ~te_flag_reg & ~busy & ~abort &
                    ~(~master & edge_evt);
   assign edge_evt = master
      ? (state_reg == spisc_pkg::SPISC_RUN && tick)
      : (enable && !ss_b_in && sck_in != sck_prev_reg);
   assign odd_edge    = ~edge_cnt_reg[0];
   assign sample_edge = edge_evt & (clock_phase ? ~odd_edge : odd_edge);
   assign shift_edge  = edge_evt & ~sample_edge &
                        ~(clock_phase & edge_cnt_reg == 4'h0);
   assign din = master ? miso_in : mosi_in;
   // with phase one the last sample edge also makes the eighth shift
   assign done = ~abort && bit_cnt_reg == spisc_pkg::LAST_BIT &&
                 (clock_phase ? sample_edge : shift_edge);
   assign rx_byte = {shift_reg[6:0], clock_phase ? din : latch_reg};

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sck_prev_reg <= 1'b0;
      end else begin
         sck_prev_reg <= sck_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg <= spisc_pkg::SPISC_IDLE;
      end else if (abort || done) begin
         state_reg <= spisc_pkg::SPISC_IDLE;
      end else begin
         unique case (state_reg)
            spisc_pkg::SPISC_IDLE:
               if (tx_take && master) state_reg <= spisc_pkg::SPISC_LEAD;
            spisc_pkg::SPISC_LEAD: // a full sck of setup before edge one: one tick here, one more in RUN
               if (tick) state_reg <= spisc_pkg::SPISC_RUN;
            spisc_pkg::SPISC_RUN:
               state_reg <= spisc_pkg::SPISC_RUN;
            default:
               state_reg <= spisc_pkg::SPISC_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         edge_cnt_reg <= 4'h0;
         bit_cnt_reg  <= 3'h0;
      end else if (abort || done) begin
         edge_cnt_reg <= 4'h0;
         bit_cnt_reg  <= 3'h0;
      end else begin
         if (edge_evt) edge_cnt_reg <= edge_cnt_reg + 4'h1;
         if (shift_edge) bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
   end

   // msb first regardless of polarity
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         shift_reg <= 8'h00;
         latch_reg <= 1'b0;
      end else begin
         if (sample_edge) latch_reg <= din;
         if (tx_take) begin
            shift_reg <= tx_buf_reg;
         end else if (done) begin
            shift_reg <= rx_byte;
         end else if (shift_edge && !abort) begin
            shift_reg <= {shift_reg[6:0], latch_reg};
         end
      end
   end

   // pins: only driven while enabled, and only in the role's direction
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sck_out     <= 1'b0;
         sck_oe_out  <= 1'b0;
         mosi_out    <= 1'b0;
         mosi_oe_out <= 1'b0;
         miso_out    <= 1'b0;
         miso_oe_out <= 1'b0;
      end else begin
         if (state_reg == spisc_pkg::SPISC_IDLE || abort) begin
            sck_out <= clock_polarity;
         end else if (edge_evt) begin
            sck_out <= ~sck_out;
         end
         sck_oe_out  <= enable & master & ~mf_evt;
         mosi_oe_out <= enable & master & ~mf_evt;
         miso_oe_out <= enable & ~master & ~ss_b_in;
         mosi_out    <= shift_reg[7];
         miso_out    <= shift_reg[7];
      end
   end

   property p_tc_set;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      done && !tc_flag_reg |=> tc_flag_reg && rx_buf_reg == $past(rx_byte);
   endproperty
   a_tc_set: assert property (p_tc_set)
      else $error("complete flag or buffer not set after byte");

   property p_tc_clear;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      $fell(tc_flag_reg) |-> $past(data_rd && tc_armed_reg);
   endproperty
   a_tc_clear: assert property (p_tc_clear)
      else $error("complete flag cleared without read sequence");

   property p_te_load;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      data_wr && te_armed_reg && te_flag_reg |=>
         !te_flag_reg && tx_buf_reg == $past(writedata_in[7:0]);
   endproperty
   a_te_load: assert property (p_te_load)
      else $error("armed data write did not load transmit buffer");

   property p_wr_ignored;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      data_wr && !te_armed_reg |=> $stable(tx_buf_reg);
   endproperty
   a_wr_ignored: assert property (p_wr_ignored)
      else $error("unarmed data write changed transmit buffer");

   property p_fault;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      mf_evt |=> mf_flag_reg && !master && state_reg == spisc_pkg::SPISC_IDLE
                 ##1 !sck_oe_out && !mosi_oe_out;
   endproperty
   a_fault: assert property (p_fault)
      else $error("mode fault did not drop master mode");

   property p_mf_clear;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      $fell(mf_flag_reg) |-> $past(ctrl1_wr && mf_armed_reg);
   endproperty
   a_mf_clear: assert property (p_mf_clear)
      else $error("fault flag cleared without read sequence");

   property p_overrun;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      done && tc_flag_reg && !tc_clear |=> $stable(rx_buf_reg);
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("unserviced byte overwritten");

   property p_queued;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      master && enable && !te_flag_reg && !abort &&
      state_reg == spisc_pkg::SPISC_IDLE |=>
         state_reg == spisc_pkg::SPISC_LEAD && te_flag_reg;
   endproperty
   a_queued: assert property (p_queued)
      else $error("queued byte not started");

   property p_bits;
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      done |-> edge_cnt_reg == spisc_pkg::LAST_EDGE;
   endproperty
   a_bits: assert property (p_bits)
      else $error("byte ended off the sixteenth edge");

endmodule

// ===== bench/spisc_remote.sv
`timescale 1ns/1ns
// remote slave on the far side of the serial link
module spisc_remote (
   input  wire logic       sck_in,
   input  wire logic       mosi_in,
   input  wire logic       sel_b_in,
   input  wire logic       clock_polarity_in,
   input  wire logic       clock_phase_in,
   input  wire logic [7:0] tx_in,
   output logic            miso_out,
   output logic [7:0]      rx_out
);
   logic [7:0] shift_reg;

   initial begin
      shift_reg = 8'h00;
      rx_out    = 8'h00;
      miso_out  = 1'b0;
   end

   // phase zero needs the first bit on the line as soon as selected
   always @(negedge sel_b_in) begin
      shift_reg = tx_in;
      miso_out  = tx_in[7];
   end

   // no pull on the line, so a released output shows the opposite level
   always @(posedge sel_b_in) miso_out = ~miso_out;

   // the shift register keeps running across bytes, so back-to-back
   // bytes echo what the master sent before
   always @(sck_in) begin
      if (!sel_b_in) begin
         if ((sck_in != clock_polarity_in) ^ clock_phase_in) begin
            shift_reg = {shift_reg[6:0], mosi_in};
            rx_out    = shift_reg;
         end else
            miso_out = shift_reg[7];
      end
   end
endmodule

// ===== bench/spi_status_data_core_test.sv
`timescale 1ns/1ns
module spi_status_data_core_test;
   logic        sys_clk_in;
   logic        rst_b_in;
   logic [2:0]  address_in;
   logic        read_in;
   logic        write_in;
   logic [31:0] writedata_in;
   logic [31:0] readdata_out;
   logic        waitrequest_out;
   logic        sck_out;
   logic        sck_oe_out;
   logic        mosi_out;
   logic        mosi_oe_out;
   logic        miso_out;
   logic        miso_oe_out;
   logic        ss_b_in;
   logic        flt;
   logic        rsel_b;
   logic        rem_miso;
   logic        sck_q;
   logic        clock_polarity;
   logic        clock_phase;
   logic [7:0]  rem_tx;
   logic [7:0]  rem_rx;
   logic [7:0]  rd;
   int          err_count;
   int          n_compared;
   int          edges;
   int          gap;
   int          gap_bad;
   int          half;
   int          e0;
   int          n;

   spisc_core uut (
      .sys_clk_in      (sys_clk_in),
      .rst_b_in        (rst_b_in),
      .address_in      (address_in),
      .read_in         (read_in),
      .write_in        (write_in),
      .byteenable_in   (4'hF),
      .writedata_in    (writedata_in),
      .readdata_out    (readdata_out),
      .waitrequest_out (waitrequest_out),
      .sck_in          (sck_oe_out ? sck_out : flt),
      .sck_out         (sck_out),
      .sck_oe_out      (sck_oe_out),
      .mosi_in         (mosi_oe_out ? mosi_out : flt),
      .mosi_out        (mosi_out),
      .mosi_oe_out     (mosi_oe_out),
      .miso_in         (miso_oe_out ? miso_out : rem_miso),
      .miso_out        (miso_out),
      .miso_oe_out     (miso_oe_out),
      .ss_b_in         (ss_b_in)
   );

   spisc_remote remote (
      .sck_in   (sck_oe_out ? sck_out : flt),
      .mosi_in  (mosi_oe_out ? mosi_out : flt),
      .sel_b_in (rsel_b),
      .clock_polarity_in  (clock_polarity),
      .clock_phase_in  (clock_phase),
      .tx_in    (rem_tx),
      .miso_out (rem_miso),
      .rx_out   (rem_rx)
   );

   initial begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end

   // counts clock edges inside frames and the spacing between them
   always @(posedge sys_clk_in) begin
      flt   <= ~flt;
      sck_q <= sck_out;
      gap   <= (sck_out !== sck_q) ? 1 : gap + 1;
      if (sck_out !== sck_q && !rsel_b) begin
         edges <= edges + 1;
         if (edges % 16 != 0 && gap != half) gap_bad <= gap_bad + 1;
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // one bus access; the extra edge keeps two requests apart
   task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
      int k;
      k = 0;
      address_in   <= a;
      writedata_in <= {24'h000000, d};
      write_in     <= wr;
      read_in      <= ~wr;
      @(posedge sys_clk_in);
      while (waitrequest_out !== 1'b0 && k < 20) begin
         @(posedge sys_clk_in);
         k++;
      end
      if (k == 20) err_count++;
      rd = readdata_out[7:0];
      write_in <= 1'b0;
      read_in  <= 1'b0;
      @(posedge sys_clk_in);
   endtask

   task automatic wait_tc;
      int k;
      k = 0;
      rd = 8'h00;
      while (rd[7] !== 1'b1 && k < 400) begin
         bus(1'b0, spisc_pkg::IDX_STATUS, 8'h00);
         k++;
      end
      check("status_tc", rd[7], 1'b1);
   endtask

   task automatic xfer(input logic [7:0] mo, so);
      e0 = edges;
      rem_tx <= so;
      rsel_b <= 1'b0;
      bus(1'b0, spisc_pkg::IDX_STATUS, 8'h00);
      check("status_te", rd[5], 1'b1);
      bus(1'b1, spisc_pkg::IDX_DATA, mo);
      wait_tc;
      bus(1'b0, spisc_pkg::IDX_DATA, 8'h00);
      check("rx_byte", rd, so);
      check("remote_rx", rem_rx, mo);
      check("edge_count", edges - e0, 16);
      bus(1'b0, spisc_pkg::IDX_STATUS, 8'h00);
      check("tc_cleared", rd[7], 1'b0);
      rsel_b <= 1'b1;
   endtask

   initial begin
      #(20 * 20000);
      err_count++;
      wrap_up;
   end

   initial begin
      {read_in, write_in, flt, sck_q, clock_polarity, clock_phase} = 6'h00;
      {address_in, writedata_in, rem_tx} = 43'h0;
      {ss_b_in, rsel_b} = 2'b11;
      {err_count, n_compared, edges, gap, gap_bad} = 160'h0;
      half = 4;
      rst_b_in = 1'b0;
      repeat (4) @(posedge sys_clk_in);
      rst_b_in <= 1'b1;
      @(posedge sys_clk_in);
      check("sck_oe_off", sck_oe_out, 1'b0);
      bus(1'b1, spisc_pkg::IDX_BAUD, 8'h11);
      bus(1'b1, spisc_pkg::IDX_CTRL1, 8'h50);
      // pin enables follow the control register one edge later
      @(posedge sys_clk_in);
      check("sck_oe_on", sck_oe_out, 1'b1);
      check("miso_oe_master", miso_oe_out, 1'b0);
      // data write before any status read must not start a frame
      e0 = edges;
      rsel_b <= 1'b0;
      bus(1'b1, spisc_pkg::IDX_DATA, 8'hC3);
      repeat (80) @(posedge sys_clk_in);
      check("unarmed_edges", edges - e0, 0);
      rsel_b <= 1'b1;
      bus(1'b0, spisc_pkg::IDX_STATUS, 8'h00);
      check("status_reset", rd, 8'h20);
      bus(1'b1, spisc_pkg::IDX_STATUS, 8'hFF);
      bus(1'b0, spisc_pkg::IDX_STATUS, 8'h00);
      check("status_ro", rd, 8'h20);
      bus(1'b0, 3'h7, 8'h00);
      check("unmapped", rd, 8'h00);
      for (int m = 0; m < 4; m++) begin
         clock_polarity = m[1];
         clock_phase = m[0];
         bus(1'b1, spisc_pkg::IDX_CTRL1, {4'h5, clock_polarity, clock_phase, 2'b00});
         @(posedge sys_clk_in);
         check("sck_idle", sck_out, clock_polarity);
         xfer(8'hA5 ^ 8'(m), 8'h3C + 8'(m));
      end
      check("sck_half", gap_bad, 0);
      // two queued bytes, receive flag left unserviced in between
      bus(1'b1, spisc_pkg::IDX_BAUD, 8'h00);
      half = 1;
      e0 = edges;
      rem_tx <= 8'h96;
      rsel_b <= 1'b0;
      bus(1'b0, spisc_pkg::IDX_STATUS, 8'h00);
      bus(1'b1, spisc_pkg::IDX_DATA, 8'h5A);
      bus(1'b0, spisc_pkg::IDX_STATUS, 8'h00);
      check("te_again", rd[5], 1'b1);
      bus(1'b1, spisc_pkg::IDX_DATA, 8'h69);
      n = 0;
      while (edges - e0 < 32 && n < 300) begin
         @(posedge sys_clk_in);
         n++;
      end
      wait_tc;
      bus(1'b0, spisc_pkg::IDX_DATA, 8'h00);
      check("overrun_keep", rd, 8'h96);
      check("remote_rx2", rem_rx, 8'h69);
      check("edges_two", edges - e0, 32);
      check("sck_half_fast", gap_bad, 0);
      rsel_b <= 1'b1;
      // select pulled low by another master in mid-frame
      bus(1'b1, spisc_pkg::IDX_CTRL2, 8'h10);
      rsel_b <= 1'b0;
      bus(1'b0, spisc_pkg::IDX_STATUS, 8'h00);
      bus(1'b1, spisc_pkg::IDX_DATA, 8'hF0);
      repeat (6) @(posedge sys_clk_in);
      ss_b_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      ss_b_in <= 1'b1;
      check("fault_sck_oe", sck_oe_out, 1'b0);
      check("fault_mosi_oe", mosi_oe_out, 1'b0);
      bus(1'b0, spisc_pkg::IDX_STATUS, 8'h00);
      check("fault_flag", rd[4], 1'b1);
      check("fault_abort", rd[7], 1'b0);
      bus(1'b0, spisc_pkg::IDX_CTRL1, 8'h00);
      check("fault_slave", rd[4], 1'b0);
      bus(1'b1, spisc_pkg::IDX_CTRL1, 8'h50);
      bus(1'b0, spisc_pkg::IDX_STATUS, 8'h00);
      check("fault_clear", rd[4], 1'b0);
      wrap_up;
   end
endmodule
